// *** shared/sdims_pkg.sv ***
/*
 * Constants for the SDRAM power-up and mode sequencer: register indexes,
 * field positions, reset values, cycle offsets and command codes.
 * Assumes one 4-bit word-index register port and an SDR SDRAM on the pins.
 */
package sdims_pkg;

    // ------------------------------------------------------------
    // register indexes
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_SYS_CTRL    = 4'h0; // system_control_zero
    localparam logic [3:0] OFF_INIT_CTRL   = 4'h1; // sdram_init_control
    localparam logic [3:0] OFF_INIT_TIMING = 4'h2; // sdram_init_timing
    localparam logic [3:0] OFF_MODE        = 4'h3; // sdram_mode_value
    localparam logic [3:0] OFF_PERIODIC_REFRESH_ON        = 4'h4; // refresh_enable_reg
    localparam logic [3:0] OFF_RFCTRL      = 4'h5; // refresh_control_reg
    localparam logic [3:0] OFF_STATUS      = 4'h6; // status, read only

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EXTERNAL_BUS_ENABLE_BIT  = 0;  // external_bus_enable
    localparam int INIT_REQUEST_BIT = 0;  // init_request
    localparam int PRC_LSB   = 0;  // init_precharge_cycles, 3 bits
    localparam int INIT_REFRESH_INTERVAL_LSB  = 4;  // init_refresh_interval, 4 bits
    localparam int INIT_REFRESH_COUNT_LSB  = 8;  // init_refresh_count, 4 bits
    localparam int PERIODIC_REFRESH_ON_BIT  = 0;  // periodic_refresh_on
    localparam int RFC_LSB   = 0;  // refresh_interval_cycles, 12 bits
    localparam int REFRESH_WAIT_CYCLES_LSB  = 16; // refresh_wait_cycles, 4 bits
    localparam int A10_BIT   = 10; // all-bank select on precharge

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [11:0] TIMING_RST = 12'h000;
    localparam logic [11:0] MODE_RST   = 12'h000;
    localparam logic [11:0] RFC_RST    = 12'h000;
    localparam logic [3:0]  REFRESH_WAIT_CYCLES_RST   = 4'h0;

    // ------------------------------------------------------------
    // cycle offsets: cycles = field code + base
    // ------------------------------------------------------------
    localparam logic [4:0] PRC_BASE  = 5'h03;
    localparam logic [4:0] INIT_REFRESH_INTERVAL_BASE = 5'h03;
    localparam logic [4:0] REFRESH_WAIT_CYCLES_BASE = 5'h01;
    localparam logic [4:0] CKE_LAG   = 5'h02; // clock cycles before cke rises
    localparam logic [4:0] MRD_CYC   = 5'h02; // gap after mode register set

    // ------------------------------------------------------------
    // commands as {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_DSL = 4'hF;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;

    typedef enum logic [3:0] {
        ST_STOPPED,
        ST_CKE_WAIT,
        ST_IDLE,
        ST_PRE_WAIT,
        ST_REF_WAIT,
        ST_READY,
        ST_MODE_WAIT,
        ST_PER_WAIT
    } sdims_state_e;

endpackage

// *** src/sdims_clk_div.sv ***
/*
 * Memory clock divider: makes the SDRAM clock from the reference clock
 * and marks the reference edge on which the memory clock falls.
 * Assumes commands change on that edge so they are stable at the next rise.
 */
`timescale 1ns/10ps
module sdims_clk_div
    import sdims_pkg::*;
#(
    parameter int HALF = 1 // reference cycles per memory clock half period
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_run,
    output logic      o_mem_clk,
    output logic      o_tick
);
    logic [7:0] cnt_q;
    logic       clk_q;
    logic       flip;

    // ------------------------------------------------------------
    // half period counter
    // ------------------------------------------------------------
    assign flip = (cnt_q == 8'(HALF - 1));

    // clock parks low when stopped so restart begins with a clean rise
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_q <= 8'h00;
            clk_q <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                cnt_q <= 8'h00;
                clk_q <= 1'b0;
            end else if (flip) begin
                cnt_q <= 8'h00;
                clk_q <= ~clk_q;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    assign o_mem_clk = clk_q;
    assign o_tick    = i_ce & i_run & flip & clk_q; // falling edge coming
endmodule

// *** src/sdims_timer.sv ***
/*
 * Loadable down counter counting memory clock cycles.
 * Assumes the step input is one reference cycle long per memory cycle.
 */
`timescale 1ns/10ps
module sdims_timer
    import sdims_pkg::*;
#(
    parameter int W = 5
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    input  wire logic         i_step,
    output logic              o_zero
);
    logic [W-1:0] cnt_q;

    // load wins over a step in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else if (i_ce) begin
            if (i_load) begin
                cnt_q <= i_value;
            end else if (i_step && cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

    assign o_zero = (cnt_q == '0);
endmodule

// *** src/sdims_sequencer.sv ***
/*
 * SDRAM power-up and mode sequencer: register port, memory clock and cke,
 * initial precharge and refreshes, mode register set, periodic refresh.
 * Assumes a single SDR SDRAM on the command pins and software that waits
 * the power-up time before asking for initialisation.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

// Notes on behaviour
// - bus enable starts clock, then cke rises
// - deselect every cycle while waiting
// - init request in idle issues all-bank precharge, after init it stays pending
// - precharge gap from code, 000b is 3
// - refresh gap from code, 0001b is 4
// - refresh repeated to programmed count, count 0 gives one
// - init done after last refresh
// - mode write issues mode register set
// - mode value issued as written, burst length not checked
// - refresh interval covers all rows
// - refresh enable starts periodic refresh
// - deselect for refresh wait after refresh
// - periodic refresh every interval plus one cycles
module sdims_sequencer
    import sdims_pkg::*;
#(
    parameter int HALF = 1 // reference cycles per memory clock half
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    output logic             o_mem_clk,
    output logic             o_mem_cke,
    output logic             o_memory_chip_select_n,
    output logic             o_mem_ras_n,
    output logic             o_mem_cas_n,
    output logic             o_mem_we_n,
    output logic      [11:0] o_mem_addr,
    output logic      [1:0]  o_mem_ba,
    output logic             o_init_done
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sdims_state_e state_q;
    sdims_state_e state_d;
    logic         external_bus_enable_q;
    logic         init_req_q;
    logic [11:0]  timing_q;
    logic [11:0]  mode_q;
    logic         mode_pend_q;
    logic         periodic_refresh_on_q;
    logic [11:0]  rfc_q;
    logic [3:0]   refresh_wait_cycles_q;
    logic [31:0]  rdata_q;
    logic [3:0]   cmd_q;
    logic [3:0]   cmd_d;
    logic [11:0]  maddr_q;
    logic [11:0]  maddr_d;
    logic [3:0]   left_q;
    logic [3:0]   left_d;
    logic         cke_q;
    logic         cke_d;
    logic         done_q;
    logic         done_d;
    logic         tick;
    logic         wait_load;
    logic [4:0]   wait_val;
    logic         wait_zero;
    logic         ivl_load;
    logic         ivl_zero;
    logic         take_req;
    logic         take_mode;
    logic [4:0]   prc_load;
    logic [4:0]   init_refresh_interval_load;
    logic [3:0]   init_refresh_count_cnt;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------

    // shared by the write and read paths
    function automatic logic hit(input logic [3:0] addr,
                                 input logic [3:0] off);
        hit = (addr == off);
    endfunction

    // ------------------------------------------------------------
    // register port, writes
    // ------------------------------------------------------------

    // plain control and timing fields
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            external_bus_enable_q   <= 1'b0;
            timing_q <= TIMING_RST;
            periodic_refresh_on_q   <= 1'b0;
            rfc_q    <= RFC_RST;
            refresh_wait_cycles_q   <= REFRESH_WAIT_CYCLES_RST;
        end else if (i_ce && i_reg_wr) begin
            if (hit(i_reg_addr, OFF_SYS_CTRL)) begin
                external_bus_enable_q <= i_reg_wdata[EXTERNAL_BUS_ENABLE_BIT];
            end
            if (hit(i_reg_addr, OFF_INIT_TIMING)) begin
                timing_q <= i_reg_wdata[11:0];
            end
            if (hit(i_reg_addr, OFF_PERIODIC_REFRESH_ON)) begin
                periodic_refresh_on_q <= i_reg_wdata[PERIODIC_REFRESH_ON_BIT];
            end
            if (hit(i_reg_addr, OFF_RFCTRL)) begin
                rfc_q  <= i_reg_wdata[RFC_LSB +: 12];
                refresh_wait_cycles_q <= i_reg_wdata[REFRESH_WAIT_CYCLES_LSB +: 4];
            end
        end
    end

    // init request: a new write wins over the take in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            init_req_q <= 1'b0;
        end else if (i_ce) begin
            init_req_q <= (init_req_q & ~take_req)
                        | (i_reg_wr & hit(i_reg_addr, OFF_INIT_CTRL)
                           & i_reg_wdata[INIT_REQUEST_BIT]);
        end
    end

    // mode value is stored as written; field legality is software's job
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mode_q <= MODE_RST;
        end else if (i_ce && i_reg_wr && hit(i_reg_addr, OFF_MODE)) begin
            mode_q <= i_reg_wdata[11:0];
        end
    end

    // a mode write marks one mode register set pending, writes before it issues merge, set wins over take
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mode_pend_q <= 1'b0;
        end else if (i_ce) begin
            mode_pend_q <= (mode_pend_q & ~take_mode)
                         | (i_reg_wr & hit(i_reg_addr, OFF_MODE));
        end
    end

    // ------------------------------------------------------------
    // register port, reads
    // ------------------------------------------------------------

    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            rdata_q <= 32'h0000_0000;
            if (i_reg_rd) begin
                if (hit(i_reg_addr, OFF_SYS_CTRL)) begin
                    rdata_q <= {31'h0000_0000, external_bus_enable_q};
                end
                if (hit(i_reg_addr, OFF_INIT_CTRL)) begin
                    rdata_q <= {31'h0000_0000, init_req_q};
                end
                if (hit(i_reg_addr, OFF_INIT_TIMING)) begin
                    rdata_q <= {20'h0_0000, timing_q};
                end
                if (hit(i_reg_addr, OFF_MODE)) begin
                    rdata_q <= {20'h0_0000, mode_q};
                end
                if (hit(i_reg_addr, OFF_PERIODIC_REFRESH_ON)) begin
                    rdata_q <= {31'h0000_0000, periodic_refresh_on_q};
                end
                if (hit(i_reg_addr, OFF_RFCTRL)) begin
                    rdata_q <= {12'h000, refresh_wait_cycles_q, 4'h0, rfc_q};
                end
                if (hit(i_reg_addr, OFF_STATUS)) begin
                    rdata_q <= {27'h000_0000, external_bus_enable_q, cke_q,
                                mode_pend_q, init_req_q, done_q};
                end
            end
        end
    end

    assign o_reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // memory clock and timers
    // ------------------------------------------------------------

    // clock runs only while the external bus is enabled
    sdims_clk_div #(
        .HALF      (HALF)
    ) u_div (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_run     (external_bus_enable_q),
        .o_mem_clk (o_mem_clk),
        .o_tick    (tick)
    );

    // gap after each issued command, in memory cycles
    sdims_timer #(
        .W         (5)
    ) u_wait (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_load    (wait_load),
        .i_value   (wait_val),
        .i_step    (tick),
        .o_zero    (wait_zero)
    );

    // periodic refresh interval; held at reload while refresh is off
    sdims_timer #(
        .W         (12)
    ) u_ivl (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_load    (ivl_load),
        .i_value   (rfc_q),
        .i_step    (tick),
        .o_zero    (ivl_zero)
    );

    // field codes to timer loads, one less than the cycle count
    assign prc_load  = 5'(timing_q[PRC_LSB +: 3]) + PRC_BASE - 5'h01;
    assign init_refresh_interval_load = 5'(timing_q[INIT_REFRESH_INTERVAL_LSB +: 4]) + INIT_REFRESH_INTERVAL_BASE - 5'h01;
    assign init_refresh_count_cnt  = timing_q[INIT_REFRESH_COUNT_LSB +: 4];

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------

    // decisions wait for a tick so pins move with the clock fall; bus off acts at once
    always_comb begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        maddr_d   = maddr_q;
        left_d    = left_q;
        cke_d     = cke_q;
        done_d    = done_q;
        wait_load = 1'b0;
        wait_val  = 5'h00;
        take_req  = 1'b0;
        take_mode = 1'b0;
        ivl_load  = ~periodic_refresh_on_q;
        if (!external_bus_enable_q) begin
            state_d = ST_STOPPED;
            cmd_d   = CMD_DSL;
            maddr_d = 12'h000;
            cke_d   = 1'b0;
            done_d  = 1'b0;
        end else if (tick) begin
            cmd_d   = CMD_DSL;
            maddr_d = 12'h000;
            case (state_q)
                ST_STOPPED: begin
                    wait_load = 1'b1;
                    wait_val  = CKE_LAG - 5'h01;
                    state_d   = ST_CKE_WAIT;
                end
                ST_CKE_WAIT: begin
                    if (wait_zero) begin
                        cke_d   = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (init_req_q) begin
                        take_req         = 1'b1;
                        cmd_d            = CMD_PRE;
                        maddr_d[A10_BIT] = 1'b1;
                        wait_load        = 1'b1;
                        wait_val         = prc_load;
                        left_d           = (init_refresh_count_cnt == 4'h0) ? 4'h1 : init_refresh_count_cnt;
                        done_d           = 1'b0;
                        state_d          = ST_PRE_WAIT;
                    end
                end
                ST_PRE_WAIT: begin
                    if (wait_zero) begin
                        cmd_d     = CMD_REF;
                        wait_load = 1'b1;
                        wait_val  = init_refresh_interval_load;
                        left_d    = left_q - 4'h1;
                        state_d   = ST_REF_WAIT;
                    end
                end
                ST_REF_WAIT: begin
                    if (wait_zero) begin
                        if (left_q != 4'h0) begin
                            cmd_d     = CMD_REF;
                            wait_load = 1'b1;
                            wait_val  = init_refresh_interval_load;
                            left_d    = left_q - 4'h1;
                        end else begin
                            done_d  = 1'b1;
                            state_d = ST_READY;
                        end
                    end
                end
                ST_READY: begin
                    // refresh first: a late refresh risks data, a late mode does not
                    if (periodic_refresh_on_q && ivl_zero) begin
                        cmd_d     = CMD_REF;
                        ivl_load  = 1'b1;
                        wait_load = 1'b1;
                        wait_val  = 5'(refresh_wait_cycles_q) + REFRESH_WAIT_CYCLES_BASE - 5'h01;
                        state_d   = ST_PER_WAIT;
                    end else if (mode_pend_q) begin
                        cmd_d     = CMD_MRS;
                        maddr_d   = mode_q;
                        take_mode = 1'b1;
                        wait_load = 1'b1;
                        wait_val  = MRD_CYC - 5'h01;
                        state_d   = ST_MODE_WAIT;
                    end
                end
                ST_MODE_WAIT, ST_PER_WAIT: begin
                    if (wait_zero) begin
                        state_d = ST_READY;
                    end
                end
                default: begin
                    state_d = ST_STOPPED;
                end
            endcase
        end
    end

    // sequencer state and registered pin values
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= ST_STOPPED;
            cmd_q   <= CMD_DSL;
            maddr_q <= 12'h000;
            left_q  <= 4'h0;
            cke_q   <= 1'b0;
            done_q  <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
            maddr_q <= maddr_d;
            left_q  <= left_d;
            cke_q   <= cke_d;
            done_q  <= done_d;
        end
    end

    // ------------------------------------------------------------
    // memory pins
    // ------------------------------------------------------------

    // bank address is zero for every command this block issues
    assign o_mem_cke              = cke_q;
    assign o_memory_chip_select_n = cmd_q[3];
    assign o_mem_ras_n            = cmd_q[2];
    assign o_mem_cas_n            = cmd_q[1];
    assign o_mem_we_n             = cmd_q[0];
    assign o_mem_addr             = maddr_q;
    assign o_mem_ba               = 2'h0;
    assign o_init_done            = done_q;

endmodule

// *** verif/sdims_seq_props.sv ***
/* assertions on the sequencer pins and register read port.
   assumes HALF=1, so one memory cycle spans two reference cycles */
`timescale 1ns/10ps
module sdims_seq_props
    import sdims_pkg::*;
#(
    parameter int HALF = 1
) (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_mem_clk,
    input wire logic        o_mem_cke,
    input wire logic        o_memory_chip_select_n,
    input wire logic        o_mem_ras_n,
    input wire logic        o_mem_cas_n,
    input wire logic        o_mem_we_n,
    input wire logic [11:0] o_mem_addr,
    input wire logic        o_init_done
);
    // ----
    // command decode
    // ----
    logic [3:0] cmd;
    assign cmd = {o_memory_chip_select_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n};
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // gap of two memory cycles of deselect
    sequence s_dsl4;
        (cmd == CMD_DSL) [*4];
    endsequence
    chk_idle_deselect: assert property (!o_mem_cke |-> cmd == CMD_DSL)
        else $error("command while cke low");
    chk_cke_clk_run: assert property ($rose(o_mem_cke) |-> $past(o_mem_clk) != $past(o_mem_clk, 2))
        else $error("cke rose without memory clock");
    chk_pre_all_bank: assert property (cmd == CMD_PRE |-> o_mem_addr[A10_BIT] && !o_init_done)
        else $error("precharge not all-bank");
    chk_pre_to_ref: assert property ($rose(cmd == CMD_PRE) |-> ##2 s_dsl4 ##[1:15] cmd == CMD_REF)
        else $error("refresh gap after precharge wrong");
    chk_init_ref_gap: assert property ($rose(cmd == CMD_REF) && !o_init_done |-> ##2 s_dsl4)
        else $error("init refresh gap too short");
    chk_done_rise: assert property ($rose(o_init_done) |-> o_mem_cke && cmd == CMD_DSL)
        else $error("done rose in bad state");
    chk_mode_held: assert property (cmd == CMD_MRS |-> o_init_done)
        else $error("mode set before init done");
    chk_mode_gap: assert property ($rose(cmd == CMD_MRS) |-> ##2 s_dsl4)
        else $error("no gap after mode set");
    chk_cmd_one_cyc: assert property ($fell(o_memory_chip_select_n) |-> ##1 !o_memory_chip_select_n ##1 o_memory_chip_select_n)
        else $error("command not one memory cycle");
    chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule
bind sdims_sequencer sdims_seq_props #(.HALF(HALF)) props_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_mem_clk(o_mem_clk), .o_mem_cke(o_mem_cke),
    .o_memory_chip_select_n(o_memory_chip_select_n), .o_mem_ras_n(o_mem_ras_n),
    .o_mem_cas_n(o_mem_cas_n), .o_mem_we_n(o_mem_we_n), .o_mem_addr(o_mem_addr),
    .o_init_done(o_init_done)
);

// *** verif/sdims_mem_model.sv ***
/* memory chip model: takes commands at memory clock rise while cke is high
   and logs precharges and refreshes with memory cycle numbers, mode sets with their address. assumes pins settle at the fall */
`timescale 1ns/10ps
module sdims_mem_model
    import sdims_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_cke,
    input wire logic [3:0]  i_cmd,
    input wire logic [11:0] i_addr,
    input wire logic        i_done
);
    // ----
    // command log
    // ----
    int          cyc = 0;
    int          done_cyc = 0;
    int          pre_q[$];
    int          ref_q[$];
    logic [11:0] mode_q[$];
    // clock stands while bus is off, so cycles count only live clocks
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (i_cke === 1'b1 && i_cmd === CMD_PRE) pre_q.push_back(cyc);
        if (i_cke === 1'b1 && i_cmd === CMD_REF) ref_q.push_back(cyc);
        if (i_cke === 1'b1 && i_cmd === CMD_MRS) mode_q.push_back(i_addr);
    end
    // moment init completion is reported
    always @(posedge i_done) begin
        done_cyc = cyc;
    end
endmodule

// *** verif/test_sdram_init_mode_sequencer.sv ***
/* self-checking bench: random init timings and mode values, periodic refresh.
   assumes HALF=1 and a 25 MHz reference clock */
`timescale 1ns/10ps
module test_sdram_init_mode_sequencer
    import sdims_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        mclk, cke, cs_n, ras_n, cas_n, we_n, done;
    logic [11:0] maddr;
    logic        ce = 1'b1;
    logic [1:0]  ba;
    int          n_cyc;
    logic [31:0] rnd = 32'h40CE;
    logic [11:0] t, m;
    int          n_errors = 0;
    int          num_checks = 0;
    int          n;
    // ----
    // design, memory and clock
    // ----
    sdims_sequencer #(.HALF(1)) dut_u (
        .i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_mem_clk(mclk), .o_mem_cke(cke), .o_memory_chip_select_n(cs_n),
        .o_mem_ras_n(ras_n), .o_mem_cas_n(cas_n), .o_mem_we_n(we_n),
        .o_mem_addr(maddr), .o_mem_ba(ba), .o_init_done(done)
    );
    sdims_mem_model mem_u (
        .i_clk(mclk), .i_cke(cke), .i_cmd({cs_n, ras_n, cas_n, we_n}),
        .i_addr(maddr), .i_done(done)
    );
    always #20 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // idle cycle after each strobe keeps one assignment per time step
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
        @(posedge clk);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd(OFF_STATUS, 32'h0);
        reg_rd(OFF_INIT_TIMING, {20'h0, TIMING_RST});
        reg_rd(OFF_RFCTRL, {12'h0, REFRESH_WAIT_CYCLES_RST, 4'h0, RFC_RST});
        reg_wr(4'hF, rnd);
        reg_rd(4'hF, 32'h0);
        for (int r = 0; r < 4; r++) begin
            rnd = lfsr(lfsr(rnd));
            t = (r == 0) ? 12'h210 : (r == 1) ? 12'h0F7 :
                {4'(rnd[9:8]) + 4'h2, rnd[7:4], 1'b0, rnd[2:0]};
            m = (r == 0) ? 12'h230 : {2'b00, rnd[12], 4'b0001, rnd[13], rnd[14], 3'b000};
            n = (t[11:8] == 4'h0) ? 1 : int'(t[11:8]);
            reg_wr(OFF_SYS_CTRL, 32'h0);
            mem_u.pre_q.delete();
            mem_u.ref_q.delete();
            mem_u.mode_q.delete();
            reg_wr(OFF_SYS_CTRL, 32'h1);
            repeat (8) @(posedge clk);
            reg_rd(OFF_STATUS, 32'h18);
            // clock enable low must freeze the memory clock
            ce <= 1'b0;
            @(posedge clk);
            n_cyc = mem_u.cyc;
            repeat (6) @(posedge clk);
            check(mem_u.cyc, n_cyc);
            ce <= 1'b1;
            // software power-up wait of 100 us at 40 ns per cycle
            repeat (2500) @(posedge clk);
            check(mem_u.pre_q.size() + mem_u.ref_q.size(), 0);
            reg_wr(OFF_INIT_TIMING, {20'h0, t});
            reg_wr(OFF_INIT_CTRL, 32'h1);
            for (int w = 0; w < 2000 && done !== 1'b1; w++) @(posedge clk);
            check(mem_u.pre_q.size(), 1);
            check(mem_u.ref_q.size(), n);
            check(mem_u.ref_q[0] - mem_u.pre_q[0], t[2:0] + 3);
            for (int k = 1; k < n; k++) check(mem_u.ref_q[k] - mem_u.ref_q[k-1], t[7:4] + 3);
            check(mem_u.done_cyc > mem_u.ref_q[n-1], 1);
            reg_rd(OFF_STATUS, 32'h19);
            reg_wr(OFF_MODE, {20'h0, m});
            repeat (8) @(posedge clk);
            check(mem_u.mode_q.size(), 1);
            check(mem_u.mode_q[0], m);
            reg_rd(OFF_MODE, {20'h0, m});
        end
        // late init request stays pending and issues nothing
        reg_wr(OFF_INIT_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        reg_rd(OFF_STATUS, 32'h1B);
        check(mem_u.pre_q.size(), 1);
        // periodic refresh every 16 memory cycles, wait 4
        reg_wr(OFF_RFCTRL, 32'h0003000F);
        mem_u.ref_q.delete();
        reg_wr(OFF_PERIODIC_REFRESH_ON, 32'h1);
        repeat (200) @(posedge clk);
        check(mem_u.ref_q.size() > 4, 1);
        for (int k = 1; k < mem_u.ref_q.size(); k++) check(mem_u.ref_q[k] - mem_u.ref_q[k-1], 16);
        reg_wr(OFF_PERIODIC_REFRESH_ON, 32'h0);
        repeat (40) @(posedge clk);
        mem_u.ref_q.delete();
        repeat (100) @(posedge clk);
        check(mem_u.ref_q.size(), 0);
        check(ba, 2'h0);
        stop_test();
    end
    // run needs about 11000 cycles
    initial begin
        #(40 * 40000);
        n_errors++;
        stop_test();
    end
endmodule
